// ===== core/lmr_core.sv
// execute slice for literal load, store, option, no-op and literal return
`timescale 1ns/1ns
module lmr_core
  import lmr_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [OP_W-1:0]    opcode,
  input  wire logic               opcode_valid,
  input  wire logic               call_push,
  input  wire logic [PC_W-1:0]    call_addr,
  output logic      [DATA_W-1:0]  work_q,
  output logic      [DATA_W-1:0]  option_q,
  output logic      [PC_W-1:0]    pc_q,
  output logic                    pc_load,
  output logic                    fetch_discard,
  output logic                    file_we,
  output logic      [FADDR_W-1:0] file_addr,
  output logic      [DATA_W-1:0]  file_wdata,
  output logic                    flags_we
);
  // decoded opcode fields
  lmr_dec_if dec_bus();
  lmr_decoder u_dec (
    .opcode (opcode),
    .dec    (dec_bus.dec)
  );
  ////////////////////////////////////////////////////////////////////
  lmr_state_t         state_q, state_d;
  logic [DATA_W-1:0]  work_d, option_d, fwd_d;
  logic [PC_W-1:0]    pc_d;
  logic [PC_W-1:0]    stk_q [STACK_D];
  logic [PC_W-1:0]    stk_d [STACK_D];
  logic               pcl_d, disc_d, fwe_d;
  logic [FADDR_W-1:0] fad_d;
  logic               exec;
  assign exec     = opcode_valid && (state_q == LMR_EXEC);
  assign flags_we = 1'b0;
  // next state
  always_comb begin
    state_d  = state_q;
    work_d   = work_q;
    option_d = option_q;
    pc_d     = pc_q;
    stk_d    = stk_q;
    pcl_d    = 1'b0;
    disc_d   = 1'b0;
    fwe_d    = 1'b0;
    fad_d    = file_addr;
    fwd_d    = file_wdata;
    if (call_push) begin
      stk_d[1] = stk_q[0];
      stk_d[0] = call_addr;
    end
    if (state_q == LMR_FLUSH) begin
      state_d = LMR_EXEC;
    end else if (exec) begin
      unique case (dec_bus.op)
        LMR_OP_LIT: begin
          work_d = dec_bus.lit;
        end
        LMR_OP_OPTION: begin
          option_d = work_q;
        end
        LMR_OP_STORE: begin
          fwe_d = 1'b1;
          fad_d = dec_bus.faddr;
          fwd_d = work_q;
        end
        LMR_OP_RET: begin
          work_d   = dec_bus.lit;
          pc_d     = stk_q[0];
          stk_d[0] = stk_q[1];
          pcl_d    = 1'b1;
          disc_d   = 1'b1;
          state_d  = LMR_FLUSH;
        end
        LMR_OP_NOP: begin
        end
        LMR_OP_OTHER: begin
        end
      endcase
    end
  end
  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q       <= LMR_EXEC;
      work_q        <= WORK_RST;
      option_q      <= OPTION_RST;
      pc_q          <= PC_RST;
      stk_q[0]      <= PC_RST;
      stk_q[1]      <= PC_RST;
      pc_load       <= 1'b0;
      fetch_discard <= 1'b0;
      file_we       <= 1'b0;
      file_addr     <= '0;
      file_wdata    <= '0;
    end else begin
      state_q       <= state_d;
      work_q        <= work_d;
      option_q      <= option_d;
      pc_q          <= pc_d;
      stk_q         <= stk_d;
      pc_load       <= pcl_d;
      fetch_discard <= disc_d;
      file_we       <= fwe_d;
      file_addr     <= fad_d;
      file_wdata    <= fwd_d;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  logic ex_lit, ex_opt, ex_ret, ex_st, ex_nop, ex_oth;
  assign ex_lit = exec && dec_bus.op == LMR_OP_LIT;
  assign ex_opt = exec && dec_bus.op == LMR_OP_OPTION;
  assign ex_ret = exec && dec_bus.op == LMR_OP_RET;
  assign ex_st  = exec && dec_bus.op == LMR_OP_STORE;
  assign ex_nop = exec && dec_bus.op == LMR_OP_NOP;
  assign ex_oth = exec && dec_bus.op == LMR_OP_OTHER;
  chk_lit_load: assert property (@(posedge clk_sys) disable iff (rst)
    ex_lit |=> work_q == $past(opcode[DATA_W-1:0]))
    else $error("literal load did not reach work");
  chk_option_load: assert property (@(posedge clk_sys) disable iff (rst)
    ex_opt |=> option_q == $past(work_q))
    else $error("option not loaded from work");
  chk_option_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !ex_opt |=> $stable(option_q))
    else $error("option changed without its opcode");
  chk_ret_work: assert property (@(posedge clk_sys) disable iff (rst)
    ex_ret |=> work_q == $past(opcode[DATA_W-1:0]) && pc_load)
    else $error("literal return did not load work");
  chk_ret_pop: assert property (@(posedge clk_sys) disable iff (rst)
    ex_ret && !call_push |=> pc_q == $past(stk_q[0]) && stk_q[0] == $past(stk_q[1]))
    else $error("return stack not popped into pc");
  chk_ret_cycles: assert property (@(posedge clk_sys) disable iff (rst)
    ex_ret |=> fetch_discard && state_q == LMR_FLUSH ##1 state_q == LMR_EXEC)
    else $error("literal return not two cycles");
  chk_flush_hold: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == LMR_FLUSH |=> $stable(work_q) && !file_we)
    else $error("discarded word was executed");
  chk_store_wr: assert property (@(posedge clk_sys) disable iff (rst)
    ex_st |=> file_we && file_wdata == $past(work_q)
      && file_addr == $past(opcode[FADDR_W-1:0]))
    else $error("store to file register wrong");
  chk_flag_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !flags_we)
    else $error("flags written by this slice");
  chk_work_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !(ex_lit || ex_ret) |=> $stable(work_q))
    else $error("work changed without a literal opcode");
  chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !exec |=> !file_we && !pc_load && !fetch_discard)
    else $error("pulses raised with no opcode taken");
  chk_nop_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    ex_nop |=> $stable(option_q) && $stable(pc_q) && !file_we && !pc_load)
    else $error("no-op changed state");
  chk_other_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    ex_oth |=> $stable(work_q) && $stable(option_q) && !file_we && !pc_load)
    else $error("unknown opcode changed state");
  chk_pc_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !ex_ret |=> $stable(pc_q))
    else $error("pc changed without a literal return");
  chk_pcl_pair: assert property (@(posedge clk_sys) disable iff (rst)
    pc_load == fetch_discard)
    else $error("pc load and discard out of step");
  chk_pcl_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    pc_load |=> !pc_load)
    else $error("pc load longer than one cycle");
  chk_flush_once: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == LMR_FLUSH |=> state_q == LMR_EXEC)
    else $error("flush longer than one cycle");
  chk_lit_single: assert property (@(posedge clk_sys) disable iff (rst)
    ex_lit |=> !pc_load && !fetch_discard && state_q == LMR_EXEC)
    else $error("literal load took more than one cycle");
  chk_lit_keep: assert property (@(posedge clk_sys) disable iff (rst)
    ex_lit |=> $stable(option_q) && $stable(pc_q) && !file_we)
    else $error("literal load touched other state");
  chk_we_source: assert property (@(posedge clk_sys) disable iff (rst)
    file_we |-> $past(ex_st))
    else $error("file write without a store opcode");
  chk_addr_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !ex_st |=> $stable(file_addr) && $stable(file_wdata))
    else $error("file address or data moved without a store");
  chk_push_order: assert property (@(posedge clk_sys) disable iff (rst)
    call_push && !ex_ret |=> stk_q[0] == $past(call_addr) && stk_q[1] == $past(stk_q[0]))
    else $error("return stack push wrong");
  chk_stack_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !call_push && !ex_ret |=> $stable(stk_q[0]) && $stable(stk_q[1]))
    else $error("return stack moved without push or pop");
  chk_store_keep: assert property (@(posedge clk_sys) disable iff (rst)
    ex_st |=> $stable(work_q) && $stable(option_q) && !pc_load)
    else $error("store touched other state");
  chk_opt_keep: assert property (@(posedge clk_sys) disable iff (rst)
    ex_opt |=> $stable(work_q) && !file_we && !pc_load)
    else $error("option load touched other state");
  chk_ret_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    ex_ret |=> !file_we && $stable(option_q))
    else $error("literal return wrote a register");
  chk_flush_no_pc: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == LMR_FLUSH |=> !pc_load && $stable(pc_q) && $stable(option_q))
    else $error("discarded word changed pc or option");
  ////////////////////////////////////////////////////////////////////
  // decode checks
  chk_decode_lit: assert property (@(posedge clk_sys) disable iff (rst)
    opcode[OP_W-1 -: 4] == NIB_LOAD_LIT |-> dec_bus.op == LMR_OP_LIT)
    else $error("literal load not decoded");
  chk_decode_ret: assert property (@(posedge clk_sys) disable iff (rst)
    opcode[OP_W-1 -: 4] == NIB_RET_LIT |-> dec_bus.op == LMR_OP_RET)
    else $error("literal return not decoded");
  chk_decode_opt: assert property (@(posedge clk_sys) disable iff (rst)
    opcode == OP_OPTION |-> dec_bus.op == LMR_OP_OPTION)
    else $error("option load not decoded");
  chk_decode_store: assert property (@(posedge clk_sys) disable iff (rst)
    opcode[OP_W-1 -: 7] == PFX_STORE |-> dec_bus.op == LMR_OP_STORE
      && dec_bus.faddr == opcode[FADDR_W-1:0])
    else $error("store not decoded");
  chk_decode_nop: assert property (@(posedge clk_sys) disable iff (rst)
    opcode == OP_NOP |-> dec_bus.op == LMR_OP_NOP)
    else $error("no-op not decoded");
  ////////////////////////////////////////////////////////////////////
  // scenarios seen
  cov_lit: cover property (@(posedge clk_sys) disable iff (rst) ex_lit);
  cov_ret: cover property (@(posedge clk_sys) disable iff (rst) ex_ret ##2 ex_lit);
  cov_store: cover property (@(posedge clk_sys) disable iff (rst) ex_st);
  cov_opt: cover property (@(posedge clk_sys) disable iff (rst) ex_opt);
  cov_drop: cover property (@(posedge clk_sys) disable iff (rst)
    state_q == LMR_FLUSH && opcode_valid);
endmodule

// ===== core/lmr_dec_if.sv
// decoded fields passed from decoder to the execute core
`timescale 1ns/1ns
interface lmr_dec_if;
  import lmr_pkg::*;
  lmr_op_t            op;
  logic [DATA_W-1:0]  lit;
  logic [FADDR_W-1:0] faddr;
  modport dec (output op, output lit, output faddr);
  modport exe (input op, input lit, input faddr);
endinterface

// ===== core/lmr_decoder.sv
// opcode field decoder
`timescale 1ns/1ns
module lmr_decoder
  import lmr_pkg::*;
(
  input  wire logic [OP_W-1:0] opcode,
  lmr_dec_if.dec               dec
);
  always_comb begin
    dec.lit   = opcode[DATA_W-1:0];
    dec.faddr = opcode[FADDR_W-1:0];
    if (opcode[OP_W-1 -: 4] == NIB_LOAD_LIT) begin
      dec.op = LMR_OP_LIT;
    end else if (opcode[OP_W-1 -: 4] == NIB_RET_LIT) begin
      dec.op = LMR_OP_RET;
    end else if (opcode == OP_OPTION) begin
      dec.op = LMR_OP_OPTION;
    end else if (opcode[OP_W-1 -: 7] == PFX_STORE) begin
      dec.op = LMR_OP_STORE;
    end else if (opcode == OP_NOP) begin
      dec.op = LMR_OP_NOP;
    end else begin
      dec.op = LMR_OP_OTHER;
    end
  end
endmodule

// ===== core/lmr_pkg.sv
// constants for the literal, move and return decode slice
// How it works
// - an opcode whose top nibble is 1100 loads its low byte into the working register in one cycle, flags untouched.
// - opcode 0000 0000 0010 copies the working register into the option register in one cycle, flags untouched.
// - an opcode 1000 kkkk kkkk loads the literal k into the working register, flags untouched.
// - a literal return pops the top return-stack entry into the program counter.
// - a literal return takes two cycles, discarding the already-fetched next word, and is one word long.
package lmr_pkg;
  localparam int OP_W      = 12;
  localparam int DATA_W    = 8;
  localparam int FADDR_W   = 5;
  localparam int PC_W      = 9;
  localparam int STACK_D   = 2;
  localparam logic [3:0] NIB_LOAD_LIT = 4'hc;
  localparam logic [3:0] NIB_RET_LIT  = 4'h8;
  localparam logic [6:0] PFX_STORE    = 7'h01;
  localparam logic [OP_W-1:0] OP_NOP    = 12'h000;
  localparam logic [OP_W-1:0] OP_OPTION = 12'h002;
  localparam logic [DATA_W-1:0] WORK_RST   = 8'h00;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
  localparam logic [PC_W-1:0]   PC_RST     = 9'h000;
  typedef enum logic [2:0] {
    LMR_OP_NOP    = 3'b000,
    LMR_OP_LIT    = 3'b001,
    LMR_OP_OPTION = 3'b010,
    LMR_OP_STORE  = 3'b011,
    LMR_OP_RET    = 3'b100,
    LMR_OP_OTHER  = 3'b101
  } lmr_op_t;
  typedef enum logic [0:0] {
    LMR_EXEC  = 1'b0,
    LMR_FLUSH = 1'b1
  } lmr_state_t;
endpackage

// ===== verification/lmr_core_tb.sv
// self-checking bench for the execute slice
`timescale 1ns/1ns
module lmr_core_tb;
  import lmr_pkg::*;
  logic                clk_sys   = 1'b0;
  logic                rst       = 1'b1;
  logic                call_push = 1'b0;
  logic [PC_W-1:0]     call_addr = 9'h000;
  logic [OP_W-1:0]     opcode;
  logic                opcode_valid;
  logic [DATA_W-1:0]   work_q, option_q, file_wdata;
  logic [PC_W-1:0]     pc_q;
  logic [FADDR_W-1:0]  file_addr;
  logic                pc_load, fetch_discard, file_we, flags_we;
  int                  bad_count = 0;
  int                  n_checks  = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 clk_sys = ~clk_sys;
  lmr_fetch_model lmr_fetch_model_i (.clk_sys(clk_sys), .opcode(opcode),
    .opcode_valid(opcode_valid));
  lmr_core lmr_core_i (.clk_sys(clk_sys), .rst(rst), .opcode(opcode),
    .opcode_valid(opcode_valid), .call_push(call_push), .call_addr(call_addr),
    .work_q(work_q), .option_q(option_q), .pc_q(pc_q), .pc_load(pc_load),
    .fetch_discard(fetch_discard), .file_we(file_we), .file_addr(file_addr),
    .file_wdata(file_wdata), .flags_we(flags_we));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("work", 8'h00, work_q);
    chk("option", 8'hff, option_q);
    chk("pc", 9'h000, pc_q);
    $display("test reset done");
  endtask
  task automatic t_lit();
    lmr_fetch_model_i.issue(12'hc5a, 1'b1);
    chk("work", 8'h5a, work_q);
    chk("flags_we", 1'b0, flags_we);
    lmr_fetch_model_i.issue(12'h000, 1'b0);
    chk("work", 8'h5a, work_q);
    chk("file_we", 1'b0, file_we);
    $display("test lit done");
  endtask
  task automatic t_store();
    @(posedge clk_sys);
    #2;
    lmr_fetch_model_i.issue(12'h02f, 1'b1);
    chk("file_we", 1'b1, file_we);
    chk("file_addr", 5'h0f, file_addr);
    chk("file_wdata", 8'h5a, file_wdata);
    lmr_fetch_model_i.issue(12'h002, 1'b0);
    chk("option", 8'h5a, option_q);
    chk("file_we", 1'b0, file_we);
    chk("flags_we", 1'b0, flags_we);
    $display("test store done");
  endtask
  task automatic t_ret();
    @(posedge clk_sys);
    #2;
    call_push = 1'b1;
    call_addr = 9'h1a3;
    @(posedge clk_sys);
    #2;
    call_addr = 9'h0c7;
    @(posedge clk_sys);
    #2;
    call_push = 1'b0;
    call_addr = 9'h138;
    lmr_fetch_model_i.issue(12'h83c, 1'b1);
    chk("work", 8'h3c, work_q);
    chk("pc", 9'h0c7, pc_q);
    chk("pc_load", 1'b1, pc_load);
    chk("fetch_discard", 1'b1, fetch_discard);
    lmr_fetch_model_i.issue(12'hc11, 1'b1);
    chk("work", 8'h3c, work_q);
    chk("pc_load", 1'b0, pc_load);
    lmr_fetch_model_i.issue(12'h844, 1'b0);
    chk("work", 8'h44, work_q);
    chk("pc", 9'h1a3, pc_q);
    chk("flags_we", 1'b0, flags_we);
    $display("test ret done");
  endtask
  task automatic t_other();
    @(posedge clk_sys);
    #2;
    lmr_fetch_model_i.idle(12'hc99);
    chk("work", 8'h44, work_q);
    lmr_fetch_model_i.issue(12'hd35, 1'b1);
    chk("work", 8'h44, work_q);
    chk("option", 8'h5a, option_q);
    chk("file_we", 1'b0, file_we);
    chk("pc_load", 1'b0, pc_load);
    lmr_fetch_model_i.issue(12'h8a1, 1'b1);
    chk("work", 8'ha1, work_q);
    chk("pc", 9'h1a3, pc_q);
    lmr_fetch_model_i.issue(12'h002, 1'b1);
    chk("option", 8'h5a, option_q);
    chk("fetch_discard", 1'b0, fetch_discard);
    lmr_fetch_model_i.issue(12'hc66, 1'b0);
    chk("work", 8'h66, work_q);
    chk("option", 8'h5a, option_q);
    $display("test other done");
  endtask
  task automatic t_rst_mid();
    @(posedge clk_sys);
    #2;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    chk("work", 8'h00, work_q);
    chk("option", 8'hff, option_q);
    chk("pc", 9'h000, pc_q);
    chk("file_we", 1'b0, file_we);
    chk("file_addr", 5'h00, file_addr);
    chk("file_wdata", 8'h00, file_wdata);
    chk("pc_load", 1'b0, pc_load);
    lmr_fetch_model_i.issue(12'h8ee, 1'b0);
    chk("work", 8'hee, work_q);
    chk("pc_load", 1'b1, pc_load);
    chk("pc", 9'h000, pc_q);
    $display("test reset mid done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #2;
    rst = 1'b0;
    t_reset();
    t_lit();
    t_store();
    t_ret();
    t_other();
    t_rst_mid();
    close_out();
  end
endmodule

// ===== verification/lmr_fetch_model.sv
// fetch stage model handing opcodes to the execute slice
`timescale 1ns/1ns
module lmr_fetch_model
  import lmr_pkg::*;
(
  input  wire logic            clk_sys,
  output logic      [OP_W-1:0] opcode,
  output logic                 opcode_valid
);
  initial begin
    opcode       = 12'hfff;
    opcode_valid = 1'b0;
  end
  // one word per call; keep leaves valid up for the next word
  task automatic issue(input logic [OP_W-1:0] op, input logic keep);
    opcode       = op;
    opcode_valid = 1'b1;
    @(posedge clk_sys);
    #2;
    if (!keep) begin
      opcode_valid = 1'b0;
      opcode       = ~op;
    end
  endtask
  // word on the bus with valid low; must be ignored
  task automatic idle(input logic [OP_W-1:0] op);
    opcode       = op;
    opcode_valid = 1'b0;
    @(posedge clk_sys);
    #2;
  endtask
endmodule
